// ==== sad_adc_dev.sv ====
// converter end: serial cycles, configuration, conversion timing and result fifo
// assumes link pins are asynchronous to clk and sampled through two flops
`timescale 1ns/1ps
module sad_adc_dev
  import sad_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // link
  sad_link_if.dev          link,
  // analog front end, millivolts
  input  wire logic [12:0] ain_mv,
  input  wire logic [12:0] reference_high_pin_mv,
  input  wire logic [12:0] reference_low_pin_mv,
  // converter status
  output logic [2:0]       channel_r,
  output logic             sampling_r,
  output logic             converting_r,
  output logic             powered_r,
  output logic             ref_internal_r,
  output logic             ref_4v_r,
  output logic [11:0]      converter_configuration_r
);
  localparam int unsigned P_CS = 0, P_FS = 1, P_SCK = 2, P_SDI = 3, P_CST = 4;

  // pin synchronisers
  logic [4:0] pin_in, s1_r, s2_r, s3_r;
  assign pin_in = {link.conversion_start_pin, link.sdi, link.sclk, link.frame_sync_in, link.cs_n};
  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        s1_r[i] <= 1'b1;
        s2_r[i] <= 1'b1;
        s3_r[i] <= 1'b1;
      end else begin
        s1_r[i] <= pin_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
      end
    end
  end

  // pin events
  wire cs_act  = !s2_r[P_CS];
  wire cs_fall = cs_act && s3_r[P_CS];
  wire fs_rise = cs_act && s2_r[P_FS] && !s3_r[P_FS];
  wire rise    = cs_act && s2_r[P_SCK] && !s3_r[P_SCK];
  wire fall    = cs_act && !s2_r[P_SCK] && s3_r[P_SCK];
  wire sdi_s   = s2_r[P_SDI];
  wire cst_low = !s2_r[P_CST];
  wire cst_rise = s2_r[P_CST] && !s3_r[P_CST];

  // configuration decode
  wire [11:0] cfg      = converter_configuration_r;
  wire [1:0]  mode     = cfg[CFG_MODE_LO +: 2];
  wire        fifo_md  = (mode != MODE_SINGLE);
  wire        ext_samp = cfg[CFG_EXT_SAMP];
  wire [3:0]  thr      = sad_thr(mode, cfg[CFG_THR_LO +: 2]);

  // serial state
  logic [4:0]  bit_cnt_r;
  logic [15:0] in_sr_r, out_sr_r;
  logic        oe_n_r, hold_r, fifo_first_r, rd_chain_r, is_rd_r, is_wr_r, is_sel_r;
  logic        int_pend_r, flush_r, arm_r, eoc_int_n_r;
  logic [3:0]  cnt_r;
  logic [2:0]  wp_r, rp_r;
  logic [11:0] mem [8];
  logic [1:0]  seq_r;

  wire [3:0] cmd     = {in_sr_r[2:0], sdi_s};
  wire       at_cmd  = rise && (bit_cnt_r == CMD_LAST);
  wire       at_last = rise && (bit_cnt_r == WORD_LAST);
  wire       cyc_beg = cs_fall || fs_rise || at_last;
  // entries left once a pop on this edge is counted, so a drained fifo is never preloaded
  wire [3:0] cnt_left = cnt_r - {3'h0, pop};
  wire       preload  = (int_pend_r || rd_chain_r) && (cnt_left != 4'h0);
  wire       pop     = at_last && is_rd_r;
  wire       sel_end = at_last && is_sel_r;

  // conversion clock: internal_oscillator or divided sclk
  logic [5:0] osc_cnt_r;
  logic [1:0] div_cnt_r;
  wire [1:0]  div_max = (cfg[CFG_DIV_LO +: 2] == 2'b10) ? 2'h3 :
                        (cfg[CFG_DIV_LO +: 2] == 2'b01) ? 2'h1 : 2'h0;
  wire osc_tick  = (osc_cnt_r == 6'(OSC_CYC - 1));
  wire sck_rise  = s2_r[P_SCK] && !s3_r[P_SCK];
  wire sck_tick  = sck_rise && (div_cnt_r == div_max);
  wire conv_tick = cfg[CFG_CLK_SCLK] ? sck_tick : osc_tick;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_cnt_r <= 6'h00;
      div_cnt_r <= 2'h0;
    end else begin
      osc_cnt_r <= osc_tick ? 6'h00 : osc_cnt_r + 6'h01;
      if (sck_rise) div_cnt_r <= (div_cnt_r == div_max) ? 2'h0 : div_cnt_r + 2'h1;
    end
  end

  // conversion trigger and sweep channel
  logic [3:0]  conv_cnt_r;
  logic [12:0] held_r;
  wire [2:0] sweep_ch = cfg[CFG_SEQ] ? {seq_r, 1'b0} : {1'b0, seq_r};
  wire sweep_md  = mode[1];
  wire stalled   = (mode == MODE_SWEEP) && int_pend_r;
  wire ext_start = ext_samp && cst_rise && !cs_act && (fifo_md || arm_r);
  wire nrm_start = !ext_samp && sel_end;
  wire start     = (ext_start || nrm_start) && !converting_r && !stalled;
  wire done      = converting_r && conv_tick && (conv_cnt_r == CONV_CLKS - 4'h1);
  wire smp_now   = ext_samp ? (cst_low && !cs_act)
                            : (is_sel_r && bit_cnt_r > CMD_LAST);

  // result scaling against the selected reference
  wire [12:0] hi_mv = ref_internal_r ? (ref_4v_r ? REF_4V_MV : REF_2V_MV)
                                     : reference_high_pin_mv;
  wire [12:0] lo_mv = ref_internal_r ? 13'h0000 : reference_low_pin_mv;
  wire [12:0] span  = (hi_mv > lo_mv) ? hi_mv - lo_mv : 13'h0001;
  wire [24:0] scaled = 25'({12'h000, held_r - lo_mv} * 25'd4095) / 25'(span);
  wire [11:0] result = (held_r <= lo_mv) ? 12'h000 :
                       (held_r >= hi_mv) ? CODE_FULL : scaled[11:0];

  // fifo level arithmetic
  wire        flush   = done && (flush_r || !fifo_md);
  wire [3:0]  base    = flush ? 4'h0 : cnt_r;
  wire        store   = done && (base < FIFO_DEPTH);
  wire [3:0]  cnt_nxt = base + {3'h0, store} - {3'h0, pop && !flush};

  always_ff @(posedge clk) begin
    if (store) mem[flush ? 3'h0 : wp_r] <= result;
  end

  // fifo pointers, level and interrupt flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 4'h0; wp_r <= 3'h0; rp_r <= 3'h0; int_pend_r <= 1'b0; flush_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      wp_r  <= (flush ? 3'h0 : wp_r) + {2'h0, store};
      rp_r  <= flush ? 3'h0 : rp_r + {2'h0, pop};
      if (done && cnt_nxt >= thr) int_pend_r <= 1'b1;
      else if (cnt_nxt < thr && (pop || flush)) int_pend_r <= 1'b0;
      else if (!fifo_md && cyc_beg) int_pend_r <= 1'b0;
      if (flush) flush_r <= 1'b0;
      else if (mode == MODE_RSWEEP && int_pend_r &&
               ((at_cmd && fifo_first_r && cmd != CMD_RD_FIFO) || cst_rise))
        flush_r <= 1'b1;
    end
  end

  // serial cycle: command decode and data shifting
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_r <= 5'h00; in_sr_r <= 16'h0000; out_sr_r <= 16'h0000;
      oe_n_r <= 1'b1; hold_r <= 1'b0; fifo_first_r <= 1'b0; rd_chain_r <= 1'b0;
      is_rd_r <= 1'b0; is_wr_r <= 1'b0; is_sel_r <= 1'b0; arm_r <= 1'b0;
      channel_r <= 3'h0; converter_configuration_r <= CFG_RST;
    end else if (!cs_act) begin
      bit_cnt_r <= 5'h00; oe_n_r <= 1'b1; hold_r <= 1'b0; fifo_first_r <= 1'b0;
      is_rd_r <= 1'b0; is_wr_r <= 1'b0; is_sel_r <= 1'b0;
    end else if (cyc_beg) begin
      if (at_last && is_wr_r)
        converter_configuration_r <= {in_sr_r[10:0], sdi_s};
      if (at_last && is_sel_r && ext_samp && !fifo_md) arm_r <= 1'b1;
      rd_chain_r   <= at_last && is_rd_r;
      bit_cnt_r    <= 5'h00;
      is_rd_r      <= 1'b0; is_wr_r <= 1'b0; is_sel_r <= 1'b0;
      hold_r       <= at_last;                                          // keep preload over 16th fall
      fifo_first_r <= preload;
      oe_n_r       <= !preload;
      out_sr_r     <= {mem[pop ? rp_r + 3'h1 : rp_r], 4'h0};
    end else begin
      if (rise) begin
        in_sr_r   <= {in_sr_r[14:0], sdi_s};
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      if (at_cmd) begin
        is_wr_r  <= (cmd == CMD_WR_CFG);
        is_sel_r <= !cmd[3];
        is_rd_r  <= (cmd == CMD_RD_FIFO) && fifo_first_r;
        if (!cmd[3]) channel_r <= cmd[2:0];
        if (cmd == CMD_RD_CFG && mode == MODE_SINGLE) begin
          out_sr_r <= {cfg, 4'h0};
          oe_n_r   <= 1'b0;
          hold_r   <= 1'b1;
        end else if (fifo_first_r && cmd != CMD_RD_FIFO) begin
          oe_n_r <= 1'b1;
        end
      end else if (fall) begin
        if (!hold_r) out_sr_r <= {out_sr_r[14:0], 1'b0};
        hold_r <= 1'b0;
      end
      if (ext_start) arm_r <= 1'b0;
    end
  end

  // conversion engine and pin outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      converting_r <= 1'b0; conv_cnt_r <= 4'h0; held_r <= 13'h0000; seq_r <= 2'h0;
      sampling_r <= 1'b0; powered_r <= 1'b0; eoc_int_n_r <= 1'b1;
      ref_internal_r <= 1'b1; ref_4v_r <= 1'b0;
    end else begin
      sampling_r <= smp_now;
      if (smp_now) held_r <= ain_mv;
      if (start) begin
        converting_r <= 1'b1;
        conv_cnt_r   <= 4'h0;
      end else if (done) begin
        converting_r <= 1'b0;
        if (sweep_md) seq_r <= seq_r + 2'h1;
      end else if (converting_r && conv_tick) begin
        conv_cnt_r <= conv_cnt_r + 4'h1;
      end
      if (!sweep_md) seq_r <= 2'h0;
      powered_r      <= cs_act || cst_low || converting_r;
      ref_internal_r <= !cfg[CFG_REF_EXT];
      ref_4v_r       <= cfg[CFG_REF_4V];
      if (fifo_md || cfg[CFG_INT_SEL]) eoc_int_n_r <= !int_pend_r;
      else eoc_int_n_r <= !(converting_r || start);
    end
  end

  assign link.sdo_o     = out_sr_r[15];
  assign link.sdo_oe_n  = oe_n_r;
  assign link.eoc_int_n = eoc_int_n_r;
  wire unused_ch = |sweep_ch;
endmodule // sad_adc_dev

// ==== sad_pkg.sv ====
// constants, fields and commands shared by both ends of the serial adc link
// assumes a single 125 MHz system clock on both ends
package sad_pkg;
  localparam int unsigned CLK_KHZ          = 125000;
  localparam int unsigned OSC_MIN_KHZ      = 3600;  // internal_oscillator floor
  localparam int unsigned OSC_CYC          = CLK_KHZ / OSC_MIN_KHZ; // longest period, rounded down
  localparam int unsigned CONV_MAX_KHZ     = 6000;  // conversion clock ceiling from sclk
  localparam int unsigned SCLK_HALF        = (CLK_KHZ + 2 * CONV_MAX_KHZ - 1) / (2 * CONV_MAX_KHZ);
  localparam int unsigned SEL_MIN_SCLKS    = 6;     // least select-cycle length
  localparam logic [3:0]  CONV_CLKS        = 4'he;  // 14 conversion clocks
  localparam logic [4:0]  WORD_LAST        = 5'h0f; // index of 16th sclk
  localparam logic [4:0]  CMD_LAST         = 5'h03; // index of 4th sclk
  localparam logic [3:0]  FIFO_DEPTH       = 4'h8;
  // converter_configuration fields
  localparam int unsigned CFG_REF_EXT      = 11;
  localparam int unsigned CFG_REF_4V       = 10;
  localparam int unsigned CFG_CLK_SCLK     = 9;
  localparam int unsigned CFG_DIV_LO       = 7;
  localparam int unsigned CFG_MODE_LO      = 5;
  localparam int unsigned CFG_EXT_SAMP     = 4;
  localparam int unsigned CFG_INT_SEL      = 3;
  localparam int unsigned CFG_SEQ          = 2;
  localparam int unsigned CFG_THR_LO       = 0;
  localparam logic [11:0] CFG_RST          = 12'h000;
  // commands in the top nibble
  localparam logic [3:0]  CMD_RD_CFG       = 4'h9;
  localparam logic [3:0]  CMD_WR_CFG       = 4'ha;
  localparam logic [3:0]  CMD_RD_FIFO      = 4'he;
  // internal reference levels in millivolts
  localparam logic [12:0] REF_2V_MV        = 13'h07d0;
  localparam logic [12:0] REF_4V_MV        = 13'h0fa0;
  localparam logic [11:0] CODE_FULL        = 12'hfff;
  // host register offsets
  localparam logic [7:0]  HREG_TX          = 8'h00;
  localparam logic [7:0]  HREG_RX          = 8'h04;
  localparam logic [7:0]  HREG_STAT        = 8'h08;
  localparam logic [7:0]  HREG_PIN         = 8'h0c;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_REPEAT = 2'b01,
    MODE_SWEEP  = 2'b10,
    MODE_RSWEEP = 2'b11
  } sad_mode_t;

  // fill level that raises the interrupt
  function automatic logic [3:0] sad_thr(input logic [1:0] mode, input logic [1:0] thr);
    logic [3:0] t;
    t = 4'h8;
    unique case (thr)
      2'b00: t = 4'h8;
      2'b01: t = 4'h6;
      2'b10: t = 4'h4;
      2'b11: t = 4'h2;
    endcase
    if (mode == MODE_SINGLE) t = 4'h1;
    return t;
  endfunction
endpackage

// ==== sad_link_if.sv ====
// serial link between the converter end and the host end
// assumes the idle sdo line is pulled high when nobody drives it
`timescale 1ns/1ps
interface sad_link_if;
  logic cs_n;
  logic frame_sync_in;
  logic sclk;
  logic sdi;
  logic conversion_start_pin;
  logic sdo_o;
  logic sdo_oe_n;
  logic sdo;
  logic eoc_int_n;

  // resolved sdo wire
  assign sdo = sdo_oe_n ? 1'b1 : sdo_o;

  modport dev  (input cs_n, frame_sync_in, sclk, sdi, conversion_start_pin,
                output sdo_o, sdo_oe_n, eoc_int_n);
  modport host (output cs_n, frame_sync_in, sclk, sdi, conversion_start_pin,
                input sdo, eoc_int_n);
endinterface

// ==== sad_adc_host.sv ====
// host end: frames a 16-bit word on the link per software write to HREG_TX while idle
// assumes the converter answers within the half sclk period it is given
`timescale 1ns/1ps
module sad_adc_host
  import sad_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // software port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [31:0]      rdata_r,
  // link
  sad_link_if.host         link
);
  typedef enum logic [1:0] {H_IDLE, H_LEAD, H_HIGH, H_LOW} sad_hstate_t;

  sad_hstate_t state_r;
  logic [4:0]  half_r;
  logic [4:0]  bits_r;
  logic [15:0] tx_r, rx_r;
  logic        cs_n_r, sclk_r, cst_r, keep_r;
  logic [1:0]  sdo_s_r, int_s_r;

  // half-period divider keeps the conversion clock within its ceiling
  wire tick  = (half_r == 5'(SCLK_HALF - 1));
  wire go    = wr_stb && addr == HREG_TX && state_r == H_IDLE;
  wire busy  = (state_r != H_IDLE);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdo_s_r <= 2'b11;
      int_s_r <= 2'b11;
    end else begin
      sdo_s_r <= {sdo_s_r[0], link.sdo};
      int_s_r <= {int_s_r[0], link.eoc_int_n};
    end
  end

  // frame sequencer: every frame spans 16 sclks, above the select minimum
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= H_IDLE; half_r <= 5'h00; bits_r <= 5'h00;
      tx_r <= 16'h0000; rx_r <= 16'h0000;
      cs_n_r <= 1'b1; sclk_r <= 1'b0; cst_r <= 1'b1; keep_r <= 1'b0;
    end else begin
      half_r <= (tick || state_r == H_IDLE) ? 5'h00 : half_r + 5'h01;
      if (wr_stb && addr == HREG_PIN) begin
        cst_r  <= wdata[0];
        keep_r <= wdata[1];
      end
      unique case (state_r)
        H_IDLE: if (go) begin
          tx_r    <= wdata[15:0];
          cs_n_r  <= 1'b0;
          bits_r  <= 5'h00;
          state_r <= H_LEAD;
        end
        H_LEAD: if (tick) state_r <= H_LOW;
        H_HIGH: if (tick) begin
          sclk_r <= 1'b0;
          tx_r   <= {tx_r[14:0], 1'b0};
          if (bits_r == WORD_LAST + 5'h01) begin
            cs_n_r  <= !keep_r;
            state_r <= H_IDLE;
          end else begin
            state_r <= H_LOW;
          end
        end
        H_LOW: if (tick) begin
          sclk_r  <= 1'b1;
          rx_r    <= {rx_r[14:0], sdo_s_r[1]};
          bits_r  <= bits_r + 5'h01;
          state_r <= H_HIGH;
        end
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rdata_r <= 32'h0000_0000;
    else if (rd_stb) begin
      unique case (addr)
        HREG_RX:   rdata_r <= {16'h0000, rx_r};
        HREG_STAT: rdata_r <= {30'h0, !int_s_r[1], busy};
        HREG_PIN:  rdata_r <= {30'h0, keep_r, cst_r};
        default:   rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign link.cs_n                 = cs_n_r;
  assign link.frame_sync_in        = 1'b1;
  assign link.sclk                 = sclk_r;
  assign link.sdi                  = tx_r[15];
  assign link.conversion_start_pin = cst_r;
endmodule // sad_adc_host

// ==== sad_link_monitor.sv ====
// checker for the serial link joining the converter end and the host end
// assumes both ends share clk; placed beside the link interface instance
`timescale 1ns/1ps
module sad_link_monitor
  import sad_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  input wire logic sdo,
  input wire logic eoc_int_n
);
  logic       sclk_d_r;
  logic [7:0] age_r;
  logic [7:0] rises_r;
  wire        sclk_chg  = sclk != sclk_d_r;
  wire        sclk_rise = sclk & ~sclk_d_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // cycles since last sclk edge, sclk rises within one select
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d_r <= 1'b0;
      age_r    <= 8'h00;
      rises_r  <= 8'h00;
    end else begin
      sclk_d_r <= sclk;
      age_r    <= sclk_chg ? 8'h00 : ((age_r == 8'hff) ? age_r : age_r + 8'h01);
      rises_r  <= cs_n ? 8'h00 : (sclk_rise ? rises_r + 8'h01 : rises_r);
    end
  end

  cs_idle_a: assert property (cs_n |-> !sclk)
    else $error("sclk high while select is released");
  sclk_half_a: assert property (sclk_chg |-> age_r >= 8'(SCLK_HALF - 1))
    else $error("sclk half period too short");
  sel_len_a: assert property ($rose(cs_n) |-> rises_r >= 8'(SEL_MIN_SCLKS))
    else $error("select shorter than six sclks");
  word_len_a: assert property ($rose(cs_n) |-> rises_r[3:0] == 4'h0)
    else $error("select not a whole number of 16-clock words");
  sdi_hold_a: assert property (sclk_rise |-> $stable(sdi))
    else $error("sdi moved at sclk rise");
  sdo_release_a: assert property (cs_n [*8] |-> sdo_oe_n)
    else $error("sdo still driven while deselected");
  sdo_wire_a: assert property (sdo == (sdo_oe_n ? 1'b1 : sdo_o))
    else $error("sdo wire does not follow its driver");
  reset_idle_a: assert property ($fell(sys_rst) |-> cs_n && sdo_oe_n && eoc_int_n)
    else $error("link not idle after reset");

  // main scenarios
  cover property ($rose(cs_n) && rises_r == 8'h20);
  cover property ($fell(eoc_int_n));
  cover property (!cs_n && !sdo_oe_n);
endmodule // sad_link_monitor

// ==== sad_serial_adc_fifo_host_port_bench.sv ====
// self-checking bench: host end drives the converter end over the link
// assumes software reaches the host end through its plain register port
`timescale 1ns/1ps
module sad_serial_adc_fifo_host_port_bench
  import sad_pkg::*;
;
  localparam int unsigned CYC_MAX = 40000;
  localparam logic [11:0] REF_CFG [3] = '{12'h800, 12'h400, 12'h003};
  logic        clk;
  logic        sys_rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [31:0] rdata;
  logic [12:0] ain_mv;
  logic [2:0]  channel;
  logic        sampling;
  logic        converting;
  logic        powered;
  logic        ref_internal;
  logic        ref_4v;
  logic [11:0] cfg;
  logic [15:0] rx;
  logic [31:0] r32;
  logic        conv_seen;
  logic        eoc_seen;
  logic        smp_seen;
  int          err_total;
  int          check_count;
  int          cyc_count;
  int          conv_len;
  int          last_len;
  int          conv_done;

  sad_link_if sad_link_if_inst ();
  sad_adc_host sad_adc_host_inst (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_r(rdata), .link(sad_link_if_inst));
  sad_adc_dev sad_adc_dev_inst (.clk(clk), .sys_rst(sys_rst), .link(sad_link_if_inst),
    .ain_mv(ain_mv), .reference_high_pin_mv(REF_4V_MV), .reference_low_pin_mv(13'h0000),
    .channel_r(channel), .sampling_r(sampling), .converting_r(converting),
    .powered_r(powered), .ref_internal_r(ref_internal), .ref_4v_r(ref_4v),
    .converter_configuration_r(cfg));
  sad_link_monitor sad_link_monitor_inst (.clk(clk), .sys_rst(sys_rst),
    .cs_n(sad_link_if_inst.cs_n), .sclk(sad_link_if_inst.sclk), .sdi(sad_link_if_inst.sdi),
    .sdo_o(sad_link_if_inst.sdo_o), .sdo_oe_n(sad_link_if_inst.sdo_oe_n),
    .sdo(sad_link_if_inst.sdo), .eoc_int_n(sad_link_if_inst.eoc_int_n));

  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // activity flags, conversion length and run limit
  always @(posedge clk) begin
    cyc_count++;
    if (converting === 1'b1) begin
      conv_seen = 1'b1;
      conv_len++;
    end else if (conv_len != 0) begin
      last_len = conv_len;
      conv_len = 0;
      conv_done++;
    end
    if (sad_link_if_inst.eoc_int_n === 1'b0) eoc_seen = 1'b1;
    if (sampling === 1'b1) smp_seen = 1'b1;
    if (cyc_count == CYC_MAX) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // one 16-bit word on the link, returns what came back on sdo
  task automatic frame(input logic [15:0] w, output logic [15:0] got);
    logic [31:0] st;
    int n;
    conv_seen = 1'b0;
    eoc_seen  = 1'b0;
    smp_seen  = 1'b0;
    sw_write(HREG_TX, {16'h0000, w});
    st = 32'h1;
    n  = 0;
    while (st[0] !== 1'b0 && n < 2000) begin
      sw_read(HREG_STAT, st);
      n++;
    end
    sw_read(HREG_RX, st);
    got = st[15:0];
  endtask

  task automatic wait_conv();
    int n;
    n = conv_done;
    repeat (1500) if (conv_done == n) @(posedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // test sequence
  initial begin
    {addr, wdata, wr_stb, rd_stb, err_total, check_count, cyc_count} = '0;
    {conv_len, last_len, conv_done, conv_seen, eoc_seen, smp_seen} = '0;
    ain_mv  = 13'h0000;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    chk(32'(cfg), 32'(CFG_RST));
    chk_bit(ref_internal, 1'b1);
    sw_read(8'h10, r32);
    chk(r32, 32'h0);
    $display("test reset done");
    foreach (REF_CFG[i]) begin
      frame({CMD_WR_CFG, REF_CFG[i]}, rx);
      chk(32'(cfg), 32'(REF_CFG[i]));
      chk_bit(ref_internal, ~REF_CFG[i][CFG_REF_EXT]);
      chk_bit(ref_4v, REF_CFG[i][CFG_REF_4V]);
      chk_bit(conv_seen | eoc_seen, 1'b0);
    end
    frame({CMD_RD_CFG, 12'h000}, rx);
    chk(32'(rx[11:0]), 32'h003);
    $display("test configuration done");
    for (int k = 0; k < 2; k++) begin
      ain_mv <= (k == 0) ? 13'h0bb8 : 13'h0000;
      frame({4'h3, 12'h000}, rx);
      chk_bit(smp_seen, 1'b1);
      wait_conv();
      chk_bit(last_len >= 13 * OSC_CYC && last_len <= 14 * (OSC_CYC + 1), 1'b1);
      chk(32'(channel), 32'h3);
      frame({CMD_RD_FIFO, 12'h000}, rx);
      chk(32'(rx), (k == 0) ? 32'hfff0 : 32'h0000);
      chk_bit(conv_seen | smp_seen, 1'b0);
    end
    repeat (50) @(posedge clk);
    chk_bit(powered, 1'b0);
    chk_bit(ref_internal, 1'b1);
    $display("test single shot done");
    frame({CMD_WR_CFG, 12'h023}, rx);
    frame({CMD_RD_CFG, 12'h000}, rx);
    chk(32'(rx[11:0]), 32'hfff);
    ain_mv <= 13'h0000;
    frame({4'h5, 12'h000}, rx);
    wait_conv();
    repeat (10) @(posedge clk);
    chk_bit(sad_link_if_inst.eoc_int_n, 1'b1);
    ain_mv <= 13'h0bb8;
    frame({4'h5, 12'h000}, rx);
    wait_conv();
    repeat (10) @(posedge clk);
    chk_bit(sad_link_if_inst.eoc_int_n, 1'b0);
    frame({CMD_RD_CFG, 12'h000}, rx);
    chk(32'(rx), 32'h0fff);
    sw_write(HREG_PIN, 32'h3);
    frame({CMD_RD_FIFO, 12'h000}, rx);
    chk(32'(rx), 32'h0000);
    frame({CMD_RD_FIFO, 12'h000}, rx);
    chk(32'(rx), 32'hfff0);
    chk_bit(conv_seen, 1'b0);
    sw_write(HREG_PIN, 32'h1);
    repeat (20) @(posedge clk);
    chk_bit(sad_link_if_inst.eoc_int_n, 1'b1);
    $display("test fifo done");
    conclude();
  end
endmodule // sad_serial_adc_fifo_host_port_bench
